// >>> logic/flash_self_program_ctrl.sv
// flash self-programming controller: table pointer, latch, holding rows, timed program/erase
`timescale 1ns/100ps
module flash_self_program_ctrl #(
   parameter int unsigned PROG_CYCLES = flash_prog_pkg::PROG_CYCLES,
   parameter int unsigned ERASE_CYCLES = flash_prog_pkg::ERASE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic por,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [2:0] sfr_idx,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire flash_prog_pkg::tbl_cmd_s tbl_cmd,
   output logic tbl_done,
   output logic fl_rd_en,
   output logic [20:0] fl_rd_word,
   input wire logic [15:0] fl_rdata,
   output flash_prog_pkg::fl_wr_s fl_wr,
   output logic fl_erase_en,
   output logic [10:0] fl_erase_blk,
   input wire logic [15:0] fetch_word,
   input wire logic fetch_decodable,
   output logic [15:0] fetch_word_out,
   output logic fetch_stall
);

   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_ERASE, ST_TIME} op_state_e;

   op_state_e state_r;
   logic [21:0] ptr_r;
   logic [7:0] latch_r;
   logic [7:0] hold_r [0:flash_prog_pkg::ROW_BYTES-1];
   logic start_r;
   logic allow_r;
   logic fault_r;
   logic erase_sel_r;
   logic op_erase_r;
   logic key1_seen_r;
   logic armed_r;
   logic [5:0] idx_r;
   logic [14:0] row_r;
   logic [31:0] timer_r;
   logic [1:0] rd_pend_r;
   logic rd_byte_sel_r;
   logic [21:0] eff_ptr;
   logic ctrl_wr;
   logic start_req;
   logic go;
   logic done;

   // pointer step touching only the low 21 bits
   function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic up);
      logic [20:0] low;
      low = up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001;
      return {p[21], low};
   endfunction : ptr_step

   // address used by the current table op; pre-increment steps first
   assign eff_ptr = (tbl_cmd.mode == flash_prog_pkg::PTR_PRE_INC) ? ptr_step(ptr_r, 1'b1)
                    : ptr_r;
   assign ctrl_wr = sfr_wr && (sfr_idx == flash_prog_pkg::IDX_CONTROL) && (state_r == ST_IDLE);
   assign start_req = ctrl_wr && sfr_wdata[flash_prog_pkg::BIT_START];
   // only a keyed start with write-allow launches; anything else is refused
   assign go = start_req && armed_r && sfr_wdata[flash_prog_pkg::BIT_ALLOW];
   assign done = (state_r == ST_TIME) && (timer_r == 32'h00000000);

   // unlock sequence: 55h then AAh back to back on the unlock port
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         key1_seen_r <= 1'b0;
         armed_r <= 1'b0;
      end else if (sfr_wr && sfr_idx == flash_prog_pkg::IDX_UNLOCK) begin
         key1_seen_r <= (sfr_wdata == flash_prog_pkg::UNLOCK_KEY1);
         armed_r <= key1_seen_r && (sfr_wdata == flash_prog_pkg::UNLOCK_KEY2);
      end else if (sfr_wr) begin
         // any other write breaks the sequence; the key is single-use
         key1_seen_r <= 1'b0;
         armed_r <= 1'b0;
      end
   end

   // control bits; no bulk erase code exists in this register
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         start_r <= 1'b0;
         allow_r <= 1'b0;
         erase_sel_r <= 1'b0;
      end else if (done) begin
         start_r <= 1'b0;
         if (op_erase_r) begin
            erase_sel_r <= 1'b0;
         end
      end else if (ctrl_wr) begin
         allow_r <= sfr_wdata[flash_prog_pkg::BIT_ALLOW];
         erase_sel_r <= sfr_wdata[flash_prog_pkg::BIT_ERASE_SEL];
         if (go) begin
            start_r <= 1'b1; // writing zero leaves it alone
         end
      end
   end

   // fault flag survives a reset that cuts an operation short
   always_ff @(posedge clk_sys) begin
      if (por) begin
         fault_r <= 1'b0;
      end else if (srst) begin
         fault_r <= fault_r | (state_r != ST_IDLE);
      end else if (go || start_req) begin
         fault_r <= 1'b1;
      end else if (done) begin
         fault_r <= 1'b0;
      end else if (ctrl_wr) begin
         fault_r <= sfr_wdata[flash_prog_pkg::BIT_FAULT];
      end
   end

   // self-timed operation sequencer
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r <= ST_IDLE;
         op_erase_r <= 1'b0;
         idx_r <= 6'h00;
         row_r <= 15'h0000;
         timer_r <= 32'h00000000;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (go) begin
                  op_erase_r <= sfr_wdata[flash_prog_pkg::BIT_ERASE_SEL];
                  row_r <= ptr_r[20:6];
                  idx_r <= 6'h00;
                  state_r <= sfr_wdata[flash_prog_pkg::BIT_ERASE_SEL] ? ST_ERASE : ST_LOAD;
               end
            end
            ST_LOAD: begin
               idx_r <= idx_r + 6'h01;
               if (idx_r == 6'h3F) begin
                  timer_r <= PROG_CYCLES - 32'h00000001;
                  state_r <= ST_TIME;
               end
            end
            ST_ERASE: begin
               timer_r <= ERASE_CYCLES - 32'h00000001;
               state_r <= ST_TIME;
            end
            ST_TIME: begin
               if (done) begin
                  state_r <= ST_IDLE;
               end else begin
                  timer_r <= timer_r - 32'h00000001;
               end
            end
         endcase
      end
   end

   // flash write and erase strobes; a row is streamed one byte per cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fl_wr <= '0;
         fl_erase_en <= 1'b0;
         fl_erase_blk <= 11'h000;
      end else begin
         fl_wr.en <= (state_r == ST_LOAD);
         fl_wr.addr <= {row_r, idx_r};
         fl_wr.data <= hold_r[idx_r];
         fl_erase_en <= (state_r == ST_ERASE);
         if (state_r == ST_IDLE && go) begin
            fl_erase_blk <= ptr_r[20:10];
         end
      end
   end

   // fetch is held while flash is busy; stall must cover the whole op
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fetch_stall <= 1'b0;
      end else if (go) begin
         fetch_stall <= 1'b1;
      end else if (done) begin
         fetch_stall <= 1'b0;
      end
   end

   // undecodable words go to the core as a no-op
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fetch_word_out <= flash_prog_pkg::NOP_WORD;
      end else begin
         fetch_word_out <= fetch_decodable ? fetch_word : flash_prog_pkg::NOP_WORD;
      end
   end

   // holding registers are never cleared by hardware
   always_ff @(posedge clk_sys) begin
      if (tbl_cmd.req && tbl_cmd.store && state_r == ST_IDLE) begin
         hold_r[eff_ptr[5:0]] <= latch_r;
      end
   end

   // table pointer: written bytewise or stepped by table ops
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ptr_r <= flash_prog_pkg::PTR_RST;
      end else if (tbl_cmd.req && state_r == ST_IDLE) begin
         unique case (tbl_cmd.mode)
            flash_prog_pkg::PTR_KEEP: ptr_r <= ptr_r;
            flash_prog_pkg::PTR_POST_INC: ptr_r <= ptr_step(ptr_r, 1'b1);
            flash_prog_pkg::PTR_POST_DEC: ptr_r <= ptr_step(ptr_r, 1'b0);
            flash_prog_pkg::PTR_PRE_INC: ptr_r <= eff_ptr;
         endcase
      end else if (sfr_wr) begin
         unique case (sfr_idx)
            flash_prog_pkg::IDX_PTR_LOW: ptr_r[7:0] <= sfr_wdata;
            flash_prog_pkg::IDX_PTR_HIGH: ptr_r[15:8] <= sfr_wdata;
            flash_prog_pkg::IDX_PTR_UPPER: ptr_r[21:16] <= sfr_wdata[5:0];
            default: ptr_r <= ptr_r;
         endcase
      end
   end

   // table read: word fetch, one cycle flash latency, then byte pick
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fl_rd_en <= 1'b0;
         fl_rd_word <= 21'h000000;
         rd_pend_r <= 2'b00;
         rd_byte_sel_r <= 1'b0;
         tbl_done <= 1'b0;
      end else begin
         fl_rd_en <= tbl_cmd.req && !tbl_cmd.store && state_r == ST_IDLE;
         rd_pend_r <= {rd_pend_r[0], tbl_cmd.req && !tbl_cmd.store && state_r == ST_IDLE};
         tbl_done <= rd_pend_r[1] || (tbl_cmd.req && tbl_cmd.store && state_r == ST_IDLE);
         if (tbl_cmd.req && state_r == ST_IDLE) begin
            fl_rd_word <= eff_ptr[21:1];
            rd_byte_sel_r <= eff_ptr[0];
         end
      end
   end

   // byte latch; a returning read wins over a register write
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         latch_r <= flash_prog_pkg::LATCH_RST;
      end else if (rd_pend_r[1]) begin
         latch_r <= rd_byte_sel_r ? fl_rdata[15:8] : fl_rdata[7:0];
      end else if (sfr_wr && sfr_idx == flash_prog_pkg::IDX_LATCH) begin
         latch_r <= sfr_wdata;
      end
   end

   // register read port, one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_idx)
            flash_prog_pkg::IDX_CONTROL:
               sfr_rdata <= {3'h0, erase_sel_r, fault_r, allow_r, start_r, 1'b0};
            flash_prog_pkg::IDX_LATCH: sfr_rdata <= latch_r;
            flash_prog_pkg::IDX_PTR_LOW: sfr_rdata <= ptr_r[7:0];
            flash_prog_pkg::IDX_PTR_HIGH: sfr_rdata <= ptr_r[15:8];
            flash_prog_pkg::IDX_PTR_UPPER: sfr_rdata <= {2'h0, ptr_r[21:16]};
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // checks
   a_start_needs_key: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(start_r) |-> $past(armed_r) && $past(sfr_wdata[flash_prog_pkg::BIT_ALLOW]))
      else $error("start accepted without unlock or write allow");
   a_stall_tracks_op: assert property (@(posedge clk_sys) disable iff (srst)
      (state_r != ST_IDLE) == fetch_stall)
      else $error("fetch stall does not match busy flash");
   a_row_len_64: assert property (@(posedge clk_sys) disable iff (srst)
      (state_r == ST_LOAD && idx_r == 6'h3F) |=> state_r == ST_TIME && fl_wr.en
      && fl_wr.addr[5:0] == 6'h3F)
      else $error("row load not 64 bytes");
   a_fault_on_start: assert property (@(posedge clk_sys) disable iff (srst)
      start_req |=> fault_r)
      else $error("fault flag not set by start");
   a_done_clears: assert property (@(posedge clk_sys) disable iff (srst)
      done |=> !start_r && !fault_r && state_r == ST_IDLE)
      else $error("completion did not clear start and fault");
   a_erase_sel_done: assert property (@(posedge clk_sys) disable iff (srst)
      (done && op_erase_r) |=> !erase_sel_r)
      else $error("erase select not cleared");
   a_ptr_top_kept: assert property (@(posedge clk_sys) disable iff (srst)
      (tbl_cmd.req && state_r == ST_IDLE) |=> ptr_r[21] == $past(ptr_r[21]))
      else $error("pointer top bit changed by table op");
   a_unlock_reads_zero: assert property (@(posedge clk_sys) disable iff (srst)
      (sfr_rd && sfr_idx == flash_prog_pkg::IDX_UNLOCK) |=> sfr_rdata == 8'h00)
      else $error("unlock port read not zero");
   a_store_target: assert property (@(posedge clk_sys) disable iff (srst)
      (tbl_cmd.req && tbl_cmd.store && state_r == ST_IDLE)
      |=> hold_r[$past(eff_ptr[5:0])] == $past(latch_r))
      else $error("table store hit wrong holding register");
   a_nop_fetch: assert property (@(posedge clk_sys) disable iff (srst)
      !fetch_decodable |=> fetch_word_out == flash_prog_pkg::NOP_WORD)
      else $error("undecodable word not replaced by no-op");
   a_read_latency: assert property (@(posedge clk_sys) disable iff (srst)
      (tbl_cmd.req && !tbl_cmd.store && state_r == ST_IDLE) |=> fl_rd_en ##2 tbl_done)
      else $error("table read timing broken");
   // targets are frozen at start, so pointer writes during an op cannot move them
   a_erase_blk_latch: assert property (@(posedge clk_sys) disable iff (srst)
      go |=> fl_erase_blk == $past(ptr_r[20:10]))
      else $error("erase block not taken from pointer bits 20 to 10");
   a_row_addr_latch: assert property (@(posedge clk_sys) disable iff (srst)
      go |=> row_r == $past(ptr_r[20:6]))
      else $error("row address not taken from pointer bits 20 to 6");
   a_erase_one_pulse: assert property (@(posedge clk_sys) disable iff (srst)
      fl_erase_en |-> op_erase_r && !fl_wr.en ##1 !fl_erase_en)
      else $error("erase strobe not a single block pulse");
   a_flash_busy_stall: assert property (@(posedge clk_sys) disable iff (srst)
      (fl_wr.en || fl_erase_en) |-> fetch_stall)
      else $error("flash written or erased while fetch runs");
   a_refused_start: assert property (@(posedge clk_sys) disable iff (srst)
      (start_req && !go) |=> state_r == ST_IDLE && !start_r && !fetch_stall)
      else $error("refused start launched an operation");
   a_allow_needed: assert property (@(posedge clk_sys) disable iff (srst)
      (ctrl_wr && !sfr_wdata[flash_prog_pkg::BIT_ALLOW]) |=> state_r == ST_IDLE)
      else $error("operation started without write allow");
   a_timer_runs_out: assert property (@(posedge clk_sys) disable iff (srst)
      (state_r == ST_TIME && timer_r != 32'h00000000) |=> state_r == ST_TIME)
      else $error("timed operation ended before the timer expired");
   a_ptr_post_dec: assert property (@(posedge clk_sys) disable iff (srst)
      (tbl_cmd.req && state_r == ST_IDLE && tbl_cmd.mode == flash_prog_pkg::PTR_POST_DEC)
      |=> ptr_r[20:0] == $past(ptr_r[20:0]) - 21'h000001)
      else $error("post-decrement did not step the pointer down");
   a_fault_kept_reset: assert property (@(posedge clk_sys)
      (srst && !por && (fault_r || state_r != ST_IDLE)) |=> fault_r)
      else $error("fault flag lost across a plain reset");
   a_store_no_flash: assert property (@(posedge clk_sys) disable iff (srst)
      (tbl_cmd.req && tbl_cmd.store && state_r == ST_IDLE) |=> !fl_wr.en)
      else $error("table store reached the flash array");

   c_program_done: cover property (@(posedge clk_sys) disable iff (srst) done && !op_erase_r);
   c_erase_done: cover property (@(posedge clk_sys) disable iff (srst) done && op_erase_r);
   c_bad_start: cover property (@(posedge clk_sys) disable iff (srst) start_req && !go);
   c_table_read: cover property (@(posedge clk_sys) disable iff (srst) rd_pend_r[1]);
   c_reset_mid_op: cover property (@(posedge clk_sys) srst && !por && state_r != ST_IDLE);

endmodule : flash_self_program_ctrl

// >>> logic/flash_prog_pkg.sv
// constants and carrier types for the flash self-programming controller
// Operation
// - flash words are 16 bits, RAM bytes 8; transfers pass through the byte latch
// - flash programming happens only as 64-byte rows from holding registers
// - self erase clears 1024-byte blocks, nothing smaller
// - user code has no way to start a whole-memory erase
// - instruction fetch stalls while program or erase runs
// - an internal timer ends every program and erase operation
// - any value may be stored; undecodable fetched words execute as no-op
// - table store writes the latch byte into a holding register only
// - table operations address bytes; no word alignment is needed
// - the unlock port stores nothing and reads as zero
// - erase select makes next start erase; erase completion clears it
// - operations proceed only with write-allow set; cleared at power-up
// - fault flag sets with start, clears when timer expires on completion
// - fault flag stays set after reset mid-operation or improper start
// - start bit is set-only by software, cleared by hardware on completion
// - pointer is 22 bits from three bytes; top bit selects config space
// - automatic pointer steps change only the low 21 bits
// - table read uses all 22 pointer bits to pick the byte
// - table store picks holding register with pointer bits 5..0
// - row program uses pointer bits 20..6 as the row address
// - erase uses pointer bits 20..10, ignoring bits 9..0
// - pointer modes: unchanged, post-increment, post-decrement, pre-increment
// - holding registers keep contents after programming; software rewrites them
package flash_prog_pkg;

   // register indices on the special-function register port
   localparam logic [2:0] IDX_CONTROL = 3'h0;
   localparam logic [2:0] IDX_LATCH = 3'h1;
   localparam logic [2:0] IDX_UNLOCK = 3'h2;
   localparam logic [2:0] IDX_PTR_LOW = 3'h3;
   localparam logic [2:0] IDX_PTR_HIGH = 3'h4;
   localparam logic [2:0] IDX_PTR_UPPER = 3'h5;

   // control register bit positions
   localparam int BIT_START = 1;
   localparam int BIT_ALLOW = 2;
   localparam int BIT_FAULT = 3;
   localparam int BIT_ERASE_SEL = 4;

   // reset values
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [21:0] PTR_RST = 22'h000000;

   // unlock keys and no-op word
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
   localparam logic [15:0] NOP_WORD = 16'h0000;

   // geometry
   localparam int PTR_W = 22;
   localparam int ADDR_W = 21;
   localparam int ROW_BYTES = 64;
   localparam int BLOCK_BYTES = 1024;

   // timing: clock rate and self-timed operation lengths
   localparam int CLK_MHZ = 125;
   localparam int PROG_TIME_US = 1000;
   localparam int ERASE_TIME_US = 2000;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

   // pointer handling of a table operation
   typedef enum logic [1:0] {
      PTR_KEEP,
      PTR_POST_INC,
      PTR_POST_DEC,
      PTR_PRE_INC
   } ptr_mode_e;

   // table instruction issued by the core
   typedef struct packed {
      logic req;
      logic store;
      ptr_mode_e mode;
   } tbl_cmd_s;

   // byte write into the flash array during a row program
   typedef struct packed {
      logic en;
      logic [20:0] addr;
      logic [7:0] data;
   } fl_wr_s;

endpackage : flash_prog_pkg

// >>> testbench/flash_array_model.sv
// flash array model: word reads, row byte writes, block erases
`timescale 1ns/100ps
module flash_array_model (
   input wire logic clk_sys,
   input wire logic fl_rd_en,
   input wire logic [20:0] fl_rd_word,
   output logic [15:0] fl_rdata,
   input wire flash_prog_pkg::fl_wr_s fl_wr,
   input wire logic fl_erase_en,
   input wire logic [10:0] fl_erase_blk
);
   logic [7:0] mem [int];
   int i;

   // erased cells read as all ones
   function automatic logic [7:0] peek(input int a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction : peek

   initial fl_rdata = 16'h0000;

   // word answer one cycle after the strobe; toggles otherwise so stale data never matches
   always @(posedge clk_sys) begin
      if (fl_rd_en) begin
         fl_rdata <= {peek(int'({fl_rd_word, 1'b1})), peek(int'({fl_rd_word, 1'b0}))};
      end else begin
         fl_rdata <= ~fl_rdata;
      end
      // programming can only clear bits, as real cells do
      if (fl_wr.en) begin
         mem[int'(fl_wr.addr)] = peek(int'(fl_wr.addr)) & fl_wr.data;
      end
      if (fl_erase_en) begin
         for (i = 0; i < 1024; i++) mem.delete(int'({fl_erase_blk, i[9:0]}));
      end
   end
endmodule : flash_array_model

// >>> testbench/flash_self_program_ctrl_tb_top.sv
// self-checking testbench for the flash self-programming controller
`timescale 1ns/100ps
module flash_self_program_ctrl_tb_top;
   localparam logic [2:0] CTL = flash_prog_pkg::IDX_CONTROL;
   localparam logic [2:0] LAT = flash_prog_pkg::IDX_LATCH;
   localparam logic [2:0] UNL = flash_prog_pkg::IDX_UNLOCK;
   localparam logic [2:0] PLO = flash_prog_pkg::IDX_PTR_LOW;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic por = 1'b1;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [2:0] sfr_idx = 3'h0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   flash_prog_pkg::tbl_cmd_s tbl_cmd = '0;
   logic tbl_done, fl_rd_en, fl_erase_en, fetch_stall;
   logic [20:0] fl_rd_word;
   logic [15:0] fl_rdata, fetch_word_out;
   logic [15:0] fetch_word = 16'h0000;
   logic fetch_decodable = 1'b1;
   flash_prog_pkg::fl_wr_s fl_wr;
   logic [10:0] fl_erase_blk;
   int err_count = 0;
   int tests_run = 0;
   int i;
   logic [7:0] el [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] ep [4] = '{8'h41, 8'h42, 8'h41, 8'h42};

   always #4 clk_sys = ~clk_sys;

   // short timer counts keep the run brief
   flash_self_program_ctrl #(.PROG_CYCLES(8), .ERASE_CYCLES(12)) u_flash_self_program_ctrl (
      .clk_sys(clk_sys), .srst(srst), .por(por), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_idx(sfr_idx), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tbl_cmd(tbl_cmd),
      .tbl_done(tbl_done), .fl_rd_en(fl_rd_en), .fl_rd_word(fl_rd_word), .fl_rdata(fl_rdata),
      .fl_wr(fl_wr), .fl_erase_en(fl_erase_en), .fl_erase_blk(fl_erase_blk),
      .fetch_word(fetch_word), .fetch_decodable(fetch_decodable),
      .fetch_word_out(fetch_word_out), .fetch_stall(fetch_stall));

   flash_array_model u_flash_array_model (
      .clk_sys(clk_sys), .fl_rd_en(fl_rd_en), .fl_rd_word(fl_rd_word), .fl_rdata(fl_rdata),
      .fl_wr(fl_wr), .fl_erase_en(fl_erase_en), .fl_erase_blk(fl_erase_blk));

   function automatic logic [7:0] dat(input int n);
      return n[7:0] ^ 8'hA5;
   endfunction : dat

   task automatic complete_run;
      $display("counts: tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // one-cycle strobe with a gap after, so no strobe is lowered and raised in one step
   task automatic wr(input logic [2:0] idx, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_wr = 1'b1;
      sfr_idx = idx;
      sfr_wdata = d;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
   endtask : wr

   task automatic rchk(input logic [2:0] idx, input logic [7:0] exp);
      @(negedge clk_sys);
      sfr_rd = 1'b1;
      sfr_idx = idx;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      check(sfr_rdata, exp);
   endtask : rchk

   task automatic ptr_set(input logic [21:0] p);
      wr(PLO, p[7:0]);
      wr(flash_prog_pkg::IDX_PTR_HIGH, p[15:8]);
      wr(flash_prog_pkg::IDX_PTR_UPPER, {2'b00, p[21:16]});
   endtask : ptr_set

   task automatic tbl(input logic st, input flash_prog_pkg::ptr_mode_e m);
      int n;
      @(negedge clk_sys);
      tbl_cmd = '{req: 1'b1, store: st, mode: m};
      for (n = 0; n < 8; n++) begin
         @(negedge clk_sys);
         tbl_cmd.req = 1'b0;
         if (tbl_done === 1'b1) break;
      end
      if (n == 8) begin
         err_count++;
         complete_run();
      end
   endtask : tbl

   // table-read one byte back through the latch
   task automatic rb(input logic [21:0] a, input logic [7:0] exp);
      ptr_set(a);
      tbl(1'b0, flash_prog_pkg::PTR_KEEP);
      rchk(LAT, exp);
   endtask : rb

   task automatic go(input logic [7:0] ctl);
      wr(UNL, flash_prog_pkg::UNLOCK_KEY1);
      wr(UNL, flash_prog_pkg::UNLOCK_KEY2);
      wr(CTL, ctl);
   endtask : go

   task automatic wait_idle;
      int n;
      for (n = 0; n < 400 && fetch_stall !== 1'b0; n++) @(negedge clk_sys);
      if (n == 400) begin
         err_count++;
         complete_run();
      end
   endtask : wait_idle

   initial begin
      el = '{dat(1), dat(1), dat(2), dat(2)};
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      por = 1'b0;
      rchk(CTL, 8'h00);
      rchk(LAT, 8'h00);
      wr(UNL, 8'h3C);
      rchk(UNL, 8'h00);
      rchk(3'h7, 8'h00);
      ptr_set(22'h3FFFFF);
      rchk(flash_prog_pkg::IDX_PTR_UPPER, 8'h3F);
      tbl(1'b0, flash_prog_pkg::PTR_POST_INC);
      rchk(PLO, 8'h00);
      rchk(flash_prog_pkg::IDX_PTR_UPPER, 8'h20);
      $display("test registers done");
      // fill holding registers, then aim inside the row with nonzero low bits
      ptr_set(22'h000440);
      for (i = 0; i < 64; i++) begin
         wr(LAT, dat(i));
         tbl(1'b1, flash_prog_pkg::PTR_POST_INC);
      end
      wr(PLO, 8'h47);
      check(u_flash_array_model.peek(32'h440), 8'hFF);
      go(8'h06);
      check(fetch_stall, 1'b1);
      rchk(CTL, 8'h0E);
      wait_idle();
      rchk(CTL, 8'h04);
      ptr_set(22'h000441);
      for (i = 0; i < 4; i++) begin
         tbl(1'b0, flash_prog_pkg::ptr_mode_e'(i));
         rchk(LAT, el[i]);
         rchk(PLO, ep[i]);
      end
      rb(22'h00047F, dat(63));
      rb(22'h00043F, 8'hFF);
      rb(22'h000480, 8'hFF);
      $display("test program done");
      // second row from the untouched holding registers
      ptr_set(22'h000800);
      go(8'h06);
      wait_idle();
      rb(22'h00083F, dat(63));
      ptr_set(22'h000755);
      go(8'h16);
      rchk(CTL, 8'h1E);
      wait_idle();
      rchk(CTL, 8'h04);
      rb(22'h000441, 8'hFF);
      rb(22'h000800, dat(0));
      $display("test erase done");
      wr(CTL, 8'h06);
      check(fetch_stall, 1'b0);
      rchk(CTL, 8'h0C);
      wr(CTL, 8'h00);
      rchk(CTL, 8'h00);
      go(8'h02);
      rchk(CTL, 8'h08);
      rb(22'h000800, dat(0));
      go(8'h06);
      repeat (3) @(negedge clk_sys);
      srst = 1'b1;
      @(negedge clk_sys);
      srst = 1'b0;
      rchk(CTL, 8'h08);
      check(fetch_stall, 1'b0);
      srst = 1'b1;
      por = 1'b1;
      @(negedge clk_sys);
      srst = 1'b0;
      por = 1'b0;
      rchk(CTL, 8'h00);
      $display("test faults done");
      fetch_word = 16'h1234;
      @(negedge clk_sys);
      check(fetch_word_out, 16'h1234);
      fetch_word = 16'h5678;
      fetch_decodable = 1'b0;
      @(negedge clk_sys);
      check(fetch_word_out, flash_prog_pkg::NOP_WORD);
      $display("test fetch done");
      complete_run();
   end
endmodule : flash_self_program_ctrl_tb_top
